// [hw/core_state_cfg.svh]
`ifndef CORE_STATE_CFG_SVH
`define CORE_STATE_CFG_SVH

// Register addresses on the special register port
`define STATUS_WORD_ADDR  8'hd0
`define STACK_PTR_ADDR    8'h81
`define ACC_ADDR          8'he0
// Status word field positions
`define CARRY_BIT         7
`define AUX_CARRY_BIT     6
`define USER_ZERO_BIT     5
`define BANK_HI_BIT       4
`define BANK_LO_BIT       3
`define OVERFLOW_BIT      2
`define USER_ONE_BIT      1
`define PARITY_BIT        0
// Reset values
`define STATUS_WORD_RESET 8'h00
`define STACK_PTR_RESET   8'h07
`define ACC_RESET         8'h00
// Bit-addressable area and multiply overflow limit
`define BIT_AREA_BASE   8'h20
`define BIT_AREA_TOP    8'h2f
`define MUL_LIMIT       16'h00ff

`endif

// [hw/core_state_pkg.sv]
`default_nettype none
package core_state_pkg;

    typedef enum logic [2:0] {
        ALU_NONE,
        ALU_ADD,
        ALU_ADD_CARRY,
        ALU_SUB_BORROW,
        ALU_MUL,
        ALU_DIV
    } alu_op_t;

    typedef enum logic [1:0] {
        RAM_IDLE,
        RAM_BYTE,
        RAM_BIT
    } ram_kind_t;

    typedef struct packed {
        alu_op_t    op;
        logic [7:0] a;
        logic [7:0] b;
    } alu_req_t;

    typedef struct packed {
        logic [7:0] result;
        logic [7:0] result_hi;
    } alu_res_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] stk_ptr;
        logic [7:0] acc;
        logic [7:0] rdata;
        logic [7:0] ram_rdata;
        logic       bit_rdata;
        alu_res_t   alu;
    } state_t;

endpackage : core_state_pkg
`default_nettype wire

// [hw/core_status_and_data_ram_regs.sv]
// How it works
// - Carry sets on add carry-out or subtract borrow, else the operation clears it.
// - Overflow sets on signed overflow, product above 255, or zero divisor.
// - Those same operations clear overflow when no overflow condition occurs.
// - Two user flags are never altered by hardware; software owns them.
// - Status bits 4 and 3 select the active working-register bank.
// - Bank codes 0..3 map to RAM 0x00, 0x08, 0x10 and 0x18.
// - Eight working registers per bank; register n sits at bank base plus n.
// - Indirect pointers come from working registers 0 or 1 of the active bank.
// - RAM bytes 0x20..0x2F are also reachable as 128 single bits.
// - Bit address equals (byte minus 0x20) times eight plus bit position.
// - Bit forms touch one bit, byte forms the whole byte.
// - Stack pointer holds the address of the last written stack location.
// - Push writes at stack pointer plus one, then increments the pointer.
// - Reset loads the stack pointer with 0x07.
// - Stack pointer may address the whole internal RAM.
`include "core_state_cfg.svh"
`default_nettype none
module core_status_and_data_ram_regs
    import core_state_pkg::*;
#(
    parameter int RAM_DEPTH = 128
) (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Special register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Arithmetic unit
    input  wire alu_req_t   alu_req,
    output alu_res_t        alu_res,
    // Data RAM: byte, bit, working register and indirect access
    input  wire ram_kind_t  ram_kind,
    input  wire logic       ram_wr,
    input  wire logic [7:0] ram_addr,
    input  wire logic       ram_indirect,
    input  wire logic       ram_work_reg,
    input  wire logic [2:0] ram_reg_num,
    input  wire logic [7:0] ram_wdata,
    input  wire logic       bit_wdata,
    output logic      [7:0] ram_rdata,
    output logic            bit_rdata,
    // Stack
    input  wire logic       push,
    input  wire logic [7:0] push_data,
    // Status view
    output logic      [1:0] bank_select_field,
    output logic      [7:0] stack_pointer,
    output logic      [7:0] program_status_word
);

    localparam int AW = $clog2(RAM_DEPTH);

    // Internal data RAM; it has no reset, so software writes a byte before reading it
    logic [7:0] mem [RAM_DEPTH];
    state_t     s_q;
    state_t     s_d;

    function automatic logic [7:0] bank_addr(
        input logic [1:0] bank_sel,
        input logic [2:0] n
    );
        bank_addr = {3'h0, bank_sel, n};
    endfunction : bank_addr

    // Addresses wrap modulo the RAM depth
    function automatic logic [AW-1:0] ram_index(
        input logic [7:0] a
    );
        ram_index = a[AW-1:0];
    endfunction : ram_index

    function automatic logic [7:0] bit_byte_of(
        input logic [7:0] bit_addr
    );
        bit_byte_of = `BIT_AREA_BASE + {4'h0, bit_addr[6:3]};
    endfunction : bit_byte_of

    function automatic logic odd_parity(
        input logic [7:0] v
    );
        odd_parity = ^v;
    endfunction : odd_parity

    // Carry, aux carry, overflow, then the result byte; carry-in is gated by the caller
    function automatic logic [10:0] add_flags(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic       cin
    );
        logic [8:0] sum;
        logic [4:0] nib;
        sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        add_flags = {sum[8], nib[4], (a[7] == b[7]) && (sum[7] != a[7]), sum[7:0]};
    endfunction : add_flags

    // Same packing as add_flags; the top bits of the 9 and 5 bit differences are borrows
    function automatic logic [10:0] sub_flags(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic       cin
    );
        logic [8:0] diff;
        logic [4:0] nib;
        diff = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        sub_flags = {diff[8], nib[4], (a[7] != b[7]) && (diff[7] != a[7]), diff[7:0]};
    endfunction : sub_flags

    // Byte address of the active-bank working register or pointer target
    logic [1:0] bank;
    logic [7:0] wr_addr;
    logic [7:0] ptr;
    logic [7:0] eff_addr;
    logic [7:0] bit_byte;
    logic [2:0] bit_pos;
    logic [7:0] sp_next;

    assign bank     = s_q.status[`BANK_HI_BIT:`BANK_LO_BIT];
    assign wr_addr  = bank_addr(bank, ram_reg_num);
    assign ptr      = mem[ram_index(bank_addr(bank, {2'h0, ram_reg_num[0]}))];
    // Working-register form wins over the indirect form when both are asked for
    assign eff_addr = ram_work_reg ? wr_addr : (ram_indirect ? ptr : ram_addr);
    assign bit_byte = bit_byte_of(ram_addr);
    assign bit_pos  = ram_addr[2:0];
    assign sp_next  = s_q.stk_ptr + 8'h01;

    always_comb begin
        logic [10:0] flags;
        logic [15:0] prod;
        logic        cin;
        logic [7:0]  status;
        flags  = 11'h000;
        prod   = 16'h0000;
        cin    = s_q.status[`CARRY_BIT];
        s_d    = s_q;
        status = s_q.status;

        // Read data stand one cycle only, zero when nothing is read
        case (reg_rd ? reg_addr : 8'h00)
            `STATUS_WORD_ADDR: s_d.rdata = s_q.status;
            `STACK_PTR_ADDR:   s_d.rdata = s_q.stk_ptr;
            `ACC_ADDR:         s_d.rdata = s_q.acc;
            default:           s_d.rdata = 8'h00;
        endcase

        if (reg_wr) begin
            case (reg_addr)
                // User flags written only by software
                `STATUS_WORD_ADDR: status = reg_wdata;
                `STACK_PTR_ADDR:   s_d.stk_ptr = reg_wdata;
                `ACC_ADDR:         s_d.acc = reg_wdata;
                default:           ;
            endcase
        end

        // Flags of an operation override a status write in the same cycle
        case (alu_req.op)
            ALU_ADD, ALU_ADD_CARRY: begin
                flags = add_flags(alu_req.a, alu_req.b, (alu_req.op == ALU_ADD_CARRY) & cin);
                status[`CARRY_BIT] = flags[10];
                status[`AUX_CARRY_BIT] = flags[9];
                status[`OVERFLOW_BIT] = flags[8];
                s_d.alu.result    = flags[7:0];
                s_d.alu.result_hi = 8'h00;
            end
            ALU_SUB_BORROW: begin
                flags = sub_flags(alu_req.a, alu_req.b, cin);
                status[`CARRY_BIT] = flags[10];
                status[`AUX_CARRY_BIT] = flags[9];
                status[`OVERFLOW_BIT] = flags[8];
                s_d.alu.result    = flags[7:0];
                s_d.alu.result_hi = 8'h00;
            end
            ALU_MUL: begin
                prod = 16'(alu_req.a) * 16'(alu_req.b);
                status[`OVERFLOW_BIT] = prod > `MUL_LIMIT;
                status[`CARRY_BIT]    = 1'b0;
                s_d.alu.result    = prod[7:0];
                s_d.alu.result_hi = prod[15:8];
            end
            ALU_DIV: begin
                status[`OVERFLOW_BIT] = alu_req.b == 8'h00;
                status[`CARRY_BIT]    = 1'b0;
                // A zero divisor gives zero quotient and remainder rather than unknowns
                s_d.alu.result    = (alu_req.b == 8'h00) ? 8'h00 : alu_req.a / alu_req.b;
                s_d.alu.result_hi = (alu_req.b == 8'h00) ? 8'h00 : alu_req.a % alu_req.b;
            end
            default: ;
        endcase

        // Pointer tracks last written slot
        // A push wins over a pointer write in the same cycle
        if (push) begin
            s_d.stk_ptr = sp_next;
        end

        // Parity follows the accumulator, write ignored
        status[`PARITY_BIT] = odd_parity(s_d.acc);
        s_d.status = status;

        s_d.ram_rdata = s_q.ram_rdata;
        s_d.bit_rdata = s_q.bit_rdata;
        // Access width set by the form
        case (ram_kind)
            RAM_BYTE: s_d.ram_rdata = mem[ram_index(eff_addr)];
            RAM_BIT:  s_d.bit_rdata = mem[ram_index(bit_byte)][bit_pos];
            default:  ;
        endcase
    end

    // RAM has no reset; a push wins over a data write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[ram_index(sp_next)] <= push_data;
        end else if (ram_wr && ram_kind == RAM_BYTE) begin
            mem[ram_index(eff_addr)] <= ram_wdata;
        end else if (ram_wr && ram_kind == RAM_BIT) begin
            mem[ram_index(bit_byte)][bit_pos] <= bit_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.status  <= `STATUS_WORD_RESET;
            s_q.stk_ptr <= `STACK_PTR_RESET;
            s_q.acc     <= `ACC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata           = s_q.rdata;
    assign alu_res             = s_q.alu;
    assign ram_rdata           = s_q.ram_rdata;
    assign bit_rdata           = s_q.bit_rdata;
    assign bank_select_field   = bank;
    assign stack_pointer       = s_q.stk_ptr;
    assign program_status_word = s_q.status;

endmodule : core_status_and_data_ram_regs
`default_nettype wire

// [verification/core_status_and_data_ram_regs_properties.sv]
`default_nettype none
module core_state_props
    import core_state_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire alu_req_t   alu_req,
    input wire logic       push,
    input wire logic [7:0] stack_pointer,
    input wire logic [7:0] program_status_word
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire logic [8:0] sum9 = {1'b0, alu_req.a} + {1'b0, alu_req.b};
    wire logic       is_add = alu_req.op == ALU_ADD;
    a_add_carry: assert property (is_add |=> program_status_word[7] == $past(sum9[8]))
        else $error("carry wrong after add");
    a_add_overflow: assert property (is_add |=>
        program_status_word[2] == $past(alu_req.a[7] == alu_req.b[7] && sum9[7] != alu_req.a[7]))
        else $error("overflow wrong after add");
    a_mul_overflow: assert property (alu_req.op == ALU_MUL |=>
        program_status_word[2] == $past(alu_req.a * alu_req.b > 16'h00ff))
        else $error("overflow wrong after multiply");
    a_div_zero: assert property (alu_req.op == ALU_DIV |=> program_status_word[2] == $past(alu_req.b == 8'h00))
        else $error("overflow wrong after divide");
    a_push_step: assert property (push && !reg_wr |=> stack_pointer == $past(stack_pointer) + 8'h01)
        else $error("push did not step pointer");
    a_parity_acc: assert property (reg_wr && reg_addr == 8'he0 |=> program_status_word[0] == ^$past(reg_wdata))
        else $error("parity does not follow accumulator");
    a_user_kept: assert property (alu_req.op != ALU_NONE && !reg_wr |=>
        program_status_word[5] == $past(program_status_word[5]) && $stable(program_status_word[1]))
        else $error("user flag altered by hardware");
    a_sp_hold: assert property (!push && !reg_wr |=> $stable(stack_pointer))
        else $error("pointer moved without push");
endmodule : core_state_props
bind core_status_and_data_ram_regs core_state_props core_state_props_i (.sys_clk, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .alu_req, .push, .stack_pointer, .program_status_word);
`default_nettype wire

// [verification/test_core_status_and_data_ram_regs.sv]
`default_nettype none
`define check(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module test_core_status_and_data_ram_regs
    import core_state_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, push = 1'b0, c;
    logic        ram_wr = 1'b0, ram_indirect = 1'b0, ram_work_reg = 1'b0, bit_wdata = 1'b0, bit_rdata;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, ram_addr = 8'h00, ram_wdata = 8'h00, push_data = 8'h00;
    logic [7:0]  reg_rdata, ram_rdata, stack_pointer, program_status_word, rd, v, e;
    logic [2:0]  ram_reg_num = 3'h0;
    logic [1:0]  bank_select_field;
    logic [10:0] x;
    alu_req_t    alu_req = '0, r;
    alu_res_t    alu_res;
    ram_kind_t   ram_kind = RAM_IDLE;
    int          n_errors = 0, n_tests = 0, seed = 32'h929dd38f;

    core_status_and_data_ram_regs core_status_and_data_ram_regs_i (.sys_clk, .nrst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .alu_req, .alu_res, .ram_kind, .ram_wr, .ram_addr, .ram_indirect,
        .ram_work_reg, .ram_reg_num, .ram_wdata, .bit_wdata, .ram_rdata, .bit_rdata, .push, .push_data,
        .bank_select_field, .stack_pointer, .program_status_word);

    initial forever #2.5 sys_clk = ~sys_clk;

    // Each bus task (reg_op, ram) is entered just after a rising edge and leaves one idle cycle behind it
    task automatic reg_op(input logic w, input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge sys_clk) {reg_wr, reg_rd} <= 2'b00;
        #1 rd = reg_rdata;
        @(posedge sys_clk);
    endtask : reg_op

    // m packs work register select, indirect select and register number
    task automatic ram(input ram_kind_t k, input logic w, input logic [7:0] a, input logic [4:0] m,
                       input logic [7:0] d);
        ram_kind <= k;
        ram_wr <= w;
        ram_addr <= a;
        {ram_work_reg, ram_indirect, ram_reg_num} <= m;
        ram_wdata <= d;
        bit_wdata <= d[0];
        @(posedge sys_clk) ram_kind <= RAM_IDLE;
        ram_wr <= 1'b0;
        #1 rd = k == RAM_BIT ? {7'h00, bit_rdata} : ram_rdata;
        @(posedge sys_clk);
    endtask : ram

    // Returns carry, aux carry, overflow and low result byte
    function automatic logic [10:0] exp_alu(alu_op_t op, logic [7:0] a, logic [7:0] b, logic c);
        logic [8:0]  s;
        logic [15:0] p;
        p = 16'(a) * 16'(b);
        case (op)
            ALU_SUB_BORROW: begin
                s = {1'b0, a} - {1'b0, b} - 9'(c);
                return {s[8], 5'(a[3:0]) < 5'(b[3:0]) + 5'(c), a[7] != b[7] && s[7] != a[7], s[7:0]};
            end
            ALU_MUL: return {2'b00, p > 16'h00ff, p[7:0]};
            ALU_DIV: return {2'b00, b == 8'h00, b == 8'h00 ? 8'h00 : a / b};
            default: begin
                s = {1'b0, a} + {1'b0, b} + 9'(c & (op == ALU_ADD_CARRY));
                return {s[8], 5'(a[3:0]) + 5'(b[3:0]) + 5'(c & (op == ALU_ADD_CARRY)) > 5'h0f,
                        a[7] == b[7] && s[7] != a[7], s[7:0]};
            end
        endcase
    endfunction : exp_alu

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        `check(stack_pointer, 8'h07)
        reg_op(1'b0, 8'h55, 8'h00);
        `check(rd, 8'h00)
        push_data <= 8'haa;
        push <= 1'b1;
        @(posedge sys_clk) push <= 1'b0;
        @(posedge sys_clk);
        ram(RAM_BYTE, 1'b0, 8'h08, 5'h00, 8'h00);
        `check({stack_pointer, rd}, 16'h08aa)
        reg_op(1'b1, 8'h81, 8'h6f);
        `check(stack_pointer, 8'h6f)
        reg_op(1'b0, 8'h81, 8'h00);
        `check(rd, 8'h6f)
        $display("test stack done");
        for (int b = 0; b < 4; b++) begin
            reg_op(1'b1, 8'hd0, 8'(b << 3));
            `check(bank_select_field, 2'(b))
            for (int n = 0; n < 8; n++) begin
                v = 8'($random(seed));
                ram(RAM_BYTE, 1'b1, 8'h00, {2'b10, 3'(n)}, v);
                ram(RAM_BYTE, 1'b0, 8'(b * 8 + n), 5'h00, 8'h00);
                `check(rd, v)
            end
            ram(RAM_BYTE, 1'b1, 8'h00, 5'h11, 8'h60 + 8'(b));
            ram(RAM_BYTE, 1'b1, 8'h00, 5'h09, v);
            ram(RAM_BYTE, 1'b0, 8'h60 + 8'(b), 5'h00, 8'h00);
            `check(rd, v)
        end
        $display("test banks done");
        for (int i = 0; i < 16; i++) begin
            e = i < 2 ? 8'(i * 127) : 8'($random(seed)) & 8'h7f;
            v = 8'($random(seed));
            ram(RAM_BYTE, 1'b1, 8'h20 + 8'(e[6:3]), 5'h00, v);
            ram(RAM_BIT, 1'b0, e, 5'h00, 8'h00);
            `check(rd[0], v[e[2:0]])
            v[e[2:0]] = ~v[e[2:0]];
            ram(RAM_BIT, 1'b1, e, 5'h00, {7'h00, v[e[2:0]]});
            ram(RAM_BYTE, 1'b0, 8'h20 + 8'(e[6:3]), 5'h00, 8'h00);
            `check(rd, v)
        end
        $display("test bits done");
        reg_op(1'b1, 8'hd0, 8'h22);
        c = 1'b0;
        for (int i = 0; i < 40; i++) begin
            r = '{alu_op_t'(3'(1 + $unsigned($random(seed)) % 5)), 8'($random(seed)), 8'($random(seed))};
            if (i == 0) r = '{ALU_ADD, 8'h80, 8'h80};
            if (i == 1) r = '{ALU_DIV, 8'h35, 8'h00};
            if (i == 2) r = '{ALU_MUL, 8'h10, 8'h10};
            alu_req <= r;
            @(posedge sys_clk) alu_req.op <= ALU_NONE;
            @(posedge sys_clk);
            x = exp_alu(r.op, r.a, r.b, c);
            c = x[10];
            `check({program_status_word[7:6] & {1'b1, r.op < ALU_MUL}, program_status_word[2], alu_res.result}, x)
            `check(alu_res.result_hi, r.op == ALU_MUL ? 8'((16'(r.a) * 16'(r.b)) >> 8) : (r.op == ALU_DIV && r.b != 8'h00) ? r.a % r.b : 8'h00)
            `check(program_status_word[5] & program_status_word[1], 1'b1)
            reg_op(1'b1, 8'he0, r.b);
            `check(program_status_word[0], ^r.b)
        end
        reg_op(1'b1, 8'hd0, 8'h01);
        `check(program_status_word, {7'h00, ^r.b})
        reg_op(1'b0, 8'hd0, 8'h00);
        `check(rd, {7'h00, ^r.b})
        reg_op(1'b0, 8'he0, 8'h00);
        `check(rd, r.b)
        $display("test arithmetic done");
        conclude();
    end
endmodule : test_core_status_and_data_ram_regs
`default_nettype wire
